//--- verilog/cwd_decoder.sv
`timescale 1ns/10ps
// Functional notes
// - Word one lives at program address 8007h, sets oscillator and protection.
// - Word two lives at program address 8008h, right after word one.
// - Word one bits 13-12, 8 and 2 always read as one.
// - Bit 11 one: clock-output pin is I/O; zero: pin drives clock.
// - Brown-out bits 10-9: 11 on, 10 run-only, 01 software, 00 off.
// - Bit 7 zero enables code protection; one leaves it off.
// - Low-voltage programming on makes the reset-pin select bit ignored.
// - Reset select one: reset pin plus pull-up; zero: digital input.
// - Bit 5 zero enables the power-up timer; one disables it.
// - Watchdog bits 4-3: 11 on, 10 run-only, 01 software, 00 off.
// - Oscillator code 00 selects internal oscillator, clock-input pin is I/O.
// - Codes 01, 10, 11 select external clock, low, medium, high power.
// - Blank or erased configuration reads all implemented fields as one.
// - Stack-error enable resets on stack over/underflow and sets a flag.
module cwd_decoder (
  input wire logic CLK_IN,
  input wire logic RST_N_IN,
  input wire logic CE_IN,
  input wire logic [15:0] ADDR_IN,
  input wire logic [cwd_pkg::WORD_W-1:0] WDATA_IN,
  input wire logic WR_IN,
  input wire logic RD_IN,
  input wire logic BULK_ERASE_IN,
  input wire logic LOAD_DONE_IN,
  input wire logic STACK_PUSH_IN,
  input wire logic STACK_POP_IN,
  output logic [cwd_pkg::WORD_W-1:0] RDATA_OUT,
  output cwd_pkg::cwd_options_t OPTIONS_OUT,
  output logic OPTIONS_VALID_OUT,
  output logic STACK_RESET_OUT,
  output logic STACK_OVERFLOW_FLAG_OUT,
  output logic STACK_UNDERFLOW_FLAG_OUT
);
  import cwd_pkg::*;

  // Nonvolatile cells: written by the external programmer port.
  logic [WORD_W-1:0] word_one = BLANK_WORD;
  logic [WORD_W-1:0] word_two = BLANK_WORD;
  logic [WORD_W-1:0] next_word_one;
  logic [WORD_W-1:0] next_word_two;
  logic [WORD_W-1:0] rdata;
  logic [WORD_W-1:0] next_rdata;

  // Cells and write data with every unimplemented position held at one.
  logic [WORD_W-1:0] view_one;
  logic [WORD_W-1:0] view_two;
  logic [WORD_W-1:0] fill_one;
  logic [WORD_W-1:0] fill_two;

  // Load sequencer: after every reset it waits for the loader, then holds.
  typedef enum logic {
    CWD_LOAD_WAIT,
    CWD_LOAD_HELD
  } cwd_load_state_t;

  cwd_load_state_t load_state;
  cwd_load_state_t next_load_state;
  logic latched;
  cwd_options_t opts;
  cwd_options_t next_opts;

  // Stack depth tracker and error flags.
  logic [4:0] depth;
  logic [4:0] next_depth;
  logic ovf;
  logic unf;
  logic next_ovf;
  logic next_unf;
  logic stk_rst;
  logic push_only;
  logic pop_only;
  logic at_top;
  logic at_bottom;
  logic over_event;
  logic under_event;
  logic error_event;

  // Stack-error reset pulse: one cycle in the error state, then back to run.
  typedef enum logic {
    CWD_STK_RUN,
    CWD_STK_ERROR
  } cwd_stk_state_t;

  cwd_stk_state_t stk_state;
  cwd_stk_state_t next_stk_state;

  // One decode serves both the load and the reset value, so the two can
  // never drift apart.
  function automatic cwd_options_t decode_words(
    input logic [WORD_W-1:0] one,
    input logic [WORD_W-1:0] two
  );
    cwd_options_t d;
    d = '0;
    // Oscillator code: 00 internal, the rest an external clock on the pin.
    unique case (one[OSCILLATOR_SELECT_LSB +: 2])
      2'h0: d.oscillator_select = CWD_OSC_INT;
      2'h1: d.oscillator_select = CWD_OSC_ECL;
      2'h2: d.oscillator_select = CWD_OSC_ECM;
      2'h3: d.oscillator_select = CWD_OSC_ECH;
    endcase
    d.clock_input_pin_is_io = (one[OSCILLATOR_SELECT_LSB +: 2] == 2'h0);
    d.clock_output_pin_drives_clock = !one[CLOCK_OUTPUT_PIN_BIT];
    // Brown-out and watchdog modes share one two-bit encoding.
    unique case (one[BROWNOUT_ENABLE_MODE_LSB +: 2])
      2'h0: d.brownout_enable_mode = CWD_EN_OFF;
      2'h1: d.brownout_enable_mode = CWD_EN_SW;
      2'h2: d.brownout_enable_mode = CWD_EN_RUN;
      2'h3: d.brownout_enable_mode = CWD_EN_ON;
    endcase
    unique case (one[WATCHDOG_ENABLE_MODE_LSB +: 2])
      2'h0: d.watchdog_enable_mode = CWD_EN_OFF;
      2'h1: d.watchdog_enable_mode = CWD_EN_SW;
      2'h2: d.watchdog_enable_mode = CWD_EN_RUN;
      2'h3: d.watchdog_enable_mode = CWD_EN_ON;
    endcase
    d.code_protect_on = !one[CP_BIT];
    d.powerup_timer_on = !one[POWERUP_TIMER_ENABLE_N_BIT];
    d.low_voltage_program_enable = two[LVP_BIT];
    // With low-voltage programming on, the pin stays a reset pin regardless.
    d.external_reset_pin_on = two[LVP_BIT] | one[RSTSEL_BIT];
    d.reset_pin_pullup_forced = d.external_reset_pin_on;
    d.debug_flag = two[DEBUG_BIT];
    d.low_power_brownout_select = two[LOW_POWER_BROWNOUT_SELECT_BIT];
    d.brownout_voltage_select = two[BROWNOUT_VOLTAGE_SELECT_BIT];
    d.stack_error_reset_enable = two[STACK_ERROR_RESET_ENABLE_BIT];
    return d;
  endfunction : decode_words

  // A part held in reset shows the options of a blank array.
  localparam cwd_options_t BLANK_OPTS =
    decode_words(BLANK_WORD, BLANK_WORD);

  // Unimplemented positions are forced to one bit by bit, so a zero written
  // there can neither be read back nor reach a decoded option.
  for (genvar b = 0; b < WORD_W; b++) begin : g_fill
    assign fill_one[b] = WDATA_IN[b] | WORD_ONE_UNIMPL[b];
    assign fill_two[b] = WDATA_IN[b] | WORD_TWO_UNIMPL[b];
    assign view_one[b] = word_one[b] | WORD_ONE_UNIMPL[b];
    assign view_two[b] = word_two[b] | WORD_TWO_UNIMPL[b];
  end

  // Programming port: a bulk erase wins over a write in the same cycle.
  always_comb begin
    next_word_one = word_one;
    next_word_two = word_two;
    if (BULK_ERASE_IN) begin
      next_word_one = BLANK_WORD;
      next_word_two = BLANK_WORD;
    end else if (WR_IN) begin
      if (ADDR_IN == ADDR_WORD_ONE) begin
        next_word_one = fill_one;
      end else if (ADDR_IN == ADDR_WORD_TWO) begin
        next_word_two = fill_two;
      end
    end
  end

  // The cells carry no reset: a device reset must never disturb what the
  // programmer stored. They start blank, like an erased array.
  always_ff @(posedge CLK_IN) begin
    if (CE_IN) begin
      word_one <= next_word_one;
      word_two <= next_word_two;
    end
  end

  // Read data: an unmapped address answers zero rather than stale data.
  always_comb begin
    next_rdata = rdata;
    if (RD_IN) begin
      if (ADDR_IN == ADDR_WORD_ONE) begin
        next_rdata = view_one;
      end else if (ADDR_IN == ADDR_WORD_TWO) begin
        next_rdata = view_two;
      end else begin
        next_rdata = '0;
      end
    end
  end

  always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      rdata <= '0;
    end else if (CE_IN) begin
      rdata <= next_rdata;
    end
  end

  // The words are copied once, after reset release, when the loader says the
  // array is readable; programming afterwards takes effect only after a reset.
  always_comb begin
    next_load_state = load_state;
    next_opts = opts;
    unique case (load_state)
      CWD_LOAD_WAIT: begin
        if (LOAD_DONE_IN) begin
          next_load_state = CWD_LOAD_HELD;
          next_opts = decode_words(view_one, view_two);
        end
      end
      CWD_LOAD_HELD: begin
        // Only a reset leaves this state, so the options cannot change.
        next_load_state = CWD_LOAD_HELD;
      end
    endcase
  end

  always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      load_state <= CWD_LOAD_WAIT;
      opts <= BLANK_OPTS;
    end else if (CE_IN) begin
      load_state <= next_load_state;
      opts <= next_opts;
    end
  end

  assign latched = (load_state == CWD_LOAD_HELD);

  // Stack tracking. A push and a pop in one cycle cancel and are no error;
  // nothing is tracked before the options are loaded.
  assign push_only = latched && STACK_PUSH_IN && !STACK_POP_IN;
  assign pop_only = latched && STACK_POP_IN && !STACK_PUSH_IN;
  assign at_top = (depth == STACK_DEPTH);
  assign at_bottom = (depth == 5'h00);
  assign over_event = push_only && at_top;
  assign under_event = pop_only && at_bottom;
  assign error_event = over_event || under_event;

  // Depth: the error reset empties the stack, as the real reset would.
  always_comb begin
    next_depth = depth;
    if (stk_rst) begin
      next_depth = 5'h00;
    end else if (push_only && !at_top) begin
      next_depth = depth + 5'h01;
    end else if (pop_only && !at_bottom) begin
      next_depth = depth - 5'h01;
    end
  end

  // Flags stay set until an external reset so software can find the cause.
  always_comb begin
    next_ovf = ovf | over_event;
    next_unf = unf | under_event;
  end

  // An error arriving while the pulse stands is absorbed by that pulse.
  always_comb begin
    next_stk_state = stk_state;
    unique case (stk_state)
      CWD_STK_RUN: begin
        if (error_event && opts.stack_error_reset_enable) begin
          next_stk_state = CWD_STK_ERROR;
        end
      end
      CWD_STK_ERROR: begin
        next_stk_state = CWD_STK_RUN;
      end
    endcase
  end

  always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      stk_state <= CWD_STK_RUN;
    end else if (CE_IN) begin
      stk_state <= next_stk_state;
    end
  end

  assign stk_rst = (stk_state == CWD_STK_ERROR);

  always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      depth <= 5'h00;
    end else if (CE_IN) begin
      depth <= next_depth;
    end
  end

  always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      ovf <= 1'b0;
      unf <= 1'b0;
    end else if (CE_IN) begin
      ovf <= next_ovf;
      unf <= next_unf;
    end
  end

  // Every output is a register or a state decode of one.
  assign RDATA_OUT = rdata;
  assign OPTIONS_OUT = opts;
  assign OPTIONS_VALID_OUT = latched;
  assign STACK_RESET_OUT = stk_rst;
  assign STACK_OVERFLOW_FLAG_OUT = ovf;
  assign STACK_UNDERFLOW_FLAG_OUT = unf;

endmodule : cwd_decoder

//--- pkg/cwd_pkg.sv
package cwd_pkg;

  localparam int WORD_W = 14;
  localparam logic [15:0] ADDR_WORD_ONE = 16'h8007;
  localparam logic [15:0] ADDR_WORD_TWO = 16'h8008;
  localparam logic [13:0] BLANK_WORD = 14'h3FFF;
  localparam logic [13:0] WORD_ONE_UNIMPL = 14'h3104;
  localparam logic [13:0] WORD_TWO_UNIMPL = 14'h01FC;
  localparam int CLOCK_OUTPUT_PIN_BIT = 11;
  localparam int BROWNOUT_ENABLE_MODE_LSB = 9;
  localparam int CP_BIT = 7;
  localparam int RSTSEL_BIT = 6;
  localparam int POWERUP_TIMER_ENABLE_N_BIT = 5;
  localparam int WATCHDOG_ENABLE_MODE_LSB = 3;
  localparam int OSCILLATOR_SELECT_LSB = 0;
  localparam int LVP_BIT = 13;
  localparam int DEBUG_BIT = 12;
  localparam int LOW_POWER_BROWNOUT_SELECT_BIT = 11;
  localparam int BROWNOUT_VOLTAGE_SELECT_BIT = 10;
  localparam int STACK_ERROR_RESET_ENABLE_BIT = 9;
  localparam logic [4:0] STACK_DEPTH = 5'h10;

  typedef enum logic [1:0] {
    CWD_EN_OFF = 2'h0,
    CWD_EN_SW = 2'h1,
    CWD_EN_RUN = 2'h2,
    CWD_EN_ON = 2'h3
  } cwd_en_mode_t;

  typedef enum logic [1:0] {
    CWD_OSC_INT = 2'h0,
    CWD_OSC_ECL = 2'h1,
    CWD_OSC_ECM = 2'h2,
    CWD_OSC_ECH = 2'h3
  } cwd_osc_t;

  typedef struct packed {
    cwd_osc_t oscillator_select;
    logic clock_input_pin_is_io;
    logic clock_output_pin_drives_clock;
    cwd_en_mode_t brownout_enable_mode;
    cwd_en_mode_t watchdog_enable_mode;
    logic code_protect_on;
    logic powerup_timer_on;
    logic external_reset_pin_on;
    logic reset_pin_pullup_forced;
    logic low_voltage_program_enable;
    logic debug_flag;
    logic low_power_brownout_select;
    logic brownout_voltage_select;
    logic stack_error_reset_enable;
  } cwd_options_t;

endpackage : cwd_pkg

//--- sim/cwd_decoder_sva.sv
`timescale 1ns/10ps
module cwd_decoder_sva (
  input wire logic CLK_IN,
  input wire logic RST_N_IN,
  input wire logic CE_IN,
  input wire logic [15:0] ADDR_IN,
  input wire logic RD_IN,
  input wire logic LOAD_DONE_IN,
  input wire logic [cwd_pkg::WORD_W-1:0] RDATA_OUT,
  input wire cwd_pkg::cwd_options_t OPTIONS_OUT,
  input wire logic OPTIONS_VALID_OUT,
  input wire logic STACK_RESET_OUT,
  input wire logic STACK_OVERFLOW_FLAG_OUT,
  input wire logic STACK_UNDERFLOW_FLAG_OUT
);
  import cwd_pkg::*;
  default clocking @(posedge CLK_IN); endclocking
  default disable iff (!RST_N_IN);
  wire rd = CE_IN && RD_IN;
  cwd_options_t o;
  assign o = OPTIONS_OUT;
  unmapped_read_a: assert property (
    rd && ADDR_IN != ADDR_WORD_ONE && ADDR_IN != ADDR_WORD_TWO
    |=> RDATA_OUT == 14'h0) else $error("Unmapped read not zero.");
  word_one_mask_a: assert property (rd && ADDR_IN == ADDR_WORD_ONE
    |=> (RDATA_OUT & WORD_ONE_UNIMPL) == WORD_ONE_UNIMPL)
    else $error("Unimplemented bits not one.");
  latch_valid_a: assert property (
    !OPTIONS_VALID_OUT && CE_IN && LOAD_DONE_IN |=> OPTIONS_VALID_OUT)
    else $error("Options not latched.");
  options_hold_a: assert property (OPTIONS_VALID_OUT
    |=> OPTIONS_VALID_OUT && $stable(OPTIONS_OUT))
    else $error("Options changed.");
  int_osc_a: assert property (
    o.clock_input_pin_is_io == (o.oscillator_select == CWD_OSC_INT))
    else $error("Clock input pin use wrong.");
  lvp_ignore_a: assert property (
    o.low_voltage_program_enable |-> o.external_reset_pin_on)
    else $error("Reset pin select not ignored.");
  stack_pulse_a: assert property (STACK_RESET_OUT |->
    o.stack_error_reset_enable && (STACK_OVERFLOW_FLAG_OUT ||
    STACK_UNDERFLOW_FLAG_OUT) ##1 !STACK_RESET_OUT)
    else $error("Stack reset pulse wrong.");
  flag_sticky_a: assert property (
    STACK_OVERFLOW_FLAG_OUT |=> STACK_OVERFLOW_FLAG_OUT)
    else $error("Overflow flag lost.");
  cover property (STACK_RESET_OUT);
  cover property ($rose(OPTIONS_VALID_OUT));
  cover property (rd && ADDR_IN == ADDR_WORD_TWO);
endmodule : cwd_decoder_sva
bind cwd_decoder cwd_decoder_sva chk (.CLK_IN, .RST_N_IN, .CE_IN,
  .ADDR_IN, .RD_IN, .LOAD_DONE_IN, .RDATA_OUT, .OPTIONS_OUT,
  .OPTIONS_VALID_OUT, .STACK_RESET_OUT, .STACK_OVERFLOW_FLAG_OUT,
  .STACK_UNDERFLOW_FLAG_OUT);

//--- sim/test_cwd_decoder.sv
`timescale 1ns/10ps
module test_cwd_decoder;
  import cwd_pkg::*;
  logic clk = 0, rst_n = 0, ce = 1, wr = 0, rd = 0, be = 0, ld = 0;
  logic push = 0, pop = 0, valid, srst, ovf, unf;
  logic [15:0] addr = 16'h0000;
  logic [13:0] wd = 14'h0000, rdata, w1, w2;
  cwd_options_t opt, exp;
  int n_mismatch = 0, checked = 0, pulses = 0;
  always #2.5 clk = ~clk;
  always @(posedge clk) if (srst === 1'h1) pulses++;
  cwd_decoder dut (.CLK_IN(clk), .RST_N_IN(rst_n), .CE_IN(ce),
    .ADDR_IN(addr), .WDATA_IN(wd), .WR_IN(wr), .RD_IN(rd),
    .BULK_ERASE_IN(be), .LOAD_DONE_IN(ld), .STACK_PUSH_IN(push),
    .STACK_POP_IN(pop), .RDATA_OUT(rdata), .OPTIONS_OUT(opt),
    .OPTIONS_VALID_OUT(valid), .STACK_RESET_OUT(srst),
    .STACK_OVERFLOW_FLAG_OUT(ovf), .STACK_UNDERFLOW_FLAG_OUT(unf));
  task results();
    $display("checked %0d n_mismatch %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : results
  task chk(input string n, input logic [31:0] got, e);
    checked++;
    if (got !== e) begin
      n_mismatch++;
      $display("[ERR] %s expected %h seen %h", n, e, got);
    end
  endtask : chk
  task acc(input logic w, input logic [15:0] a, input logic [13:0] d);
    @(posedge clk);
    wr <= w;
    rd <= !w;
    addr <= a;
    wd <= d;
    @(posedge clk);
    wr <= 1'h0;
    rd <= 1'h0;
  endtask : acc
  task rdc(input logic [15:0] a, input logic [13:0] e);
    acc(1'h0, a, 14'h0000);
    @(negedge clk);
    chk("rdata", rdata, e);
  endtask : rdc
  // Boot repeats the full power-up path so every latch starts fresh.
  task boot();
    rst_n <= 1'h0;
    repeat (2) @(posedge clk);
    rst_n <= 1'h1;
    @(posedge clk);
    ld <= 1'h1;
    @(posedge clk);
    ld <= 1'h0;
    @(negedge clk);
    chk("valid", valid, 1'h1);
  endtask : boot
  function automatic cwd_options_t dec(logic [13:0] a, b);
    dec = '{cwd_osc_t'(a[1:0]), a[1:0] == 2'h0, !a[11],
      cwd_en_mode_t'(a[10:9]), cwd_en_mode_t'(a[4:3]), !a[7], !a[5],
      a[6] | b[13], a[6], b[13], b[12], b[11], b[10], b[9]};
  endfunction : dec
  initial begin
    #50000;
    n_mismatch++;
    results();
  end
  initial begin
    void'($urandom(32'h9FD2));
    boot();
    rdc(ADDR_WORD_ONE, BLANK_WORD);
    rdc(ADDR_WORD_TWO, BLANK_WORD);
    chk("blank", opt, dec(BLANK_WORD, BLANK_WORD));
    for (int i = 0; i < 4; i++) begin
      w1 = 14'($urandom);
      w2 = 14'($urandom);
      // The pull-up reading is only unambiguous with select set.
      w1 = {w1[13:11], 2'(i), w1[8:7], w1[6] | i == 3, w1[5], 2'(i),
        w1[2], 2'(i)};
      w2 = {i == 3, 1'h1, w2[11:10], 1'h1, w2[8:0]};
      acc(1'h1, ADDR_WORD_ONE, w1);
      acc(1'h1, ADDR_WORD_TWO, w2);
      acc(1'h1, 16'h8009, 14'h0000);
      rdc(ADDR_WORD_ONE, w1 | WORD_ONE_UNIMPL);
      rdc(ADDR_WORD_TWO, w2 | WORD_TWO_UNIMPL);
      rdc(16'h8006, 14'h0000);
      boot();
      exp = dec(w1, w2);
      chk("opt", opt, exp);
      acc(1'h1, ADDR_WORD_ONE, ~w1);
      chk("hold", opt, exp);
      pulses = 0;
      @(posedge clk);
      push <= 1'h1;
      repeat (17) @(posedge clk);
      push <= 1'h0;
      repeat (3) @(negedge clk);
      chk("ovf", ovf, 1'h1);
      @(posedge clk);
      pop <= 1'h1;
      @(posedge clk);
      pop <= 1'h0;
      repeat (3) @(negedge clk);
      chk("unf", unf, 1'h1);
      chk("pulses", pulses, 32'h2);
    end
    @(posedge clk);
    be <= 1'h1;
    @(posedge clk);
    be <= 1'h0;
    rdc(ADDR_WORD_ONE, BLANK_WORD);
    rdc(ADDR_WORD_TWO, BLANK_WORD);
    // A write while the clock enable is low must leave the cell blank.
    ce <= 1'h0;
    acc(1'h1, ADDR_WORD_ONE, 14'h0000);
    ce <= 1'h1;
    rdc(ADDR_WORD_ONE, BLANK_WORD);
    results();
  end
endmodule : test_cwd_decoder
